// ---- design/lpc_serial_port.sv ----
// Serial port of a 16-bit linear codec with Wishbone registers and transmit FIFO
//
// Overview of operation
// - Transmit samples leave as 16-bit two's complement, least significant bit first.
// - Transmit data pin is released whenever no sample bit is driven.
// - Falling transmit sync starts shifting one 16-bit sample out.
// - Falling receive sync starts shifting one 16-bit sample in.
// - Receive data is 16-bit two's complement, least significant bit first.
// - Transmit disable high stops the transmit side; low enables it while control bit CTRL_TX_DIS is clear.
// - Receive disable high stops the receive side; low enables it while control bit CTRL_RX_DIS is clear.
// - Receive gain select high gives +3 dB, low gives 0 dB while control bit CTRL_RX_GAIN is clear.
// - One sample per frame each way, giving an 8 kHz rate.
// - Operation starts at edge A, first clock fall after sync low.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module lpc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int LVL_W = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Fill level
  output logic [LVL_W-1:0] level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [LVL_W-1:0] FULL = LVL_W'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [LVL_W-1:0] level_ff, nxt_level;
  logic push, pop;

  assign in_ready_o = (level_ff != FULL);
  assign out_valid_o = (level_ff != '0);
  assign out_data_o = mem[rd_ptr_ff];
  assign level_o = level_ff;

  always_comb begin
    push = in_valid_i & in_ready_o;
    pop = out_ready_i & out_valid_o;
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_level = level_ff;
    if (push && !pop) begin
      nxt_level = level_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_level = level_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      level_ff <= nxt_level;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end
endmodule : lpc_fifo

////////////////////////////////////////////////////////////////////////////////
module lpc_serial_port
  import lpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transmit pins
  input wire logic tx_master_clock_i,
  input wire logic tx_frame_sync_n_i,
  input wire logic tx_disable_i,
  output logic tx_serial_data_o,
  output logic tx_serial_data_oe_n_o,
  // Receive pins
  input wire logic rx_master_clock_i,
  input wire logic rx_frame_sync_n_i,
  input wire logic rx_serial_data_i,
  input wire logic rx_disable_i,
  input wire logic rx_gain_select_i,
  output logic rx_gain_o
);
  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction : fell

  function automatic logic rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction : rose

  // Previous pin levels for edge detection
  logic txclk_q_ff, rxclk_q_ff, txsync_q_ff, rxsync_q_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txclk_q_ff <= 1'b0;
      rxclk_q_ff <= 1'b0;
      txsync_q_ff <= 1'b1;
      rxsync_q_ff <= 1'b1;
    end else begin
      txclk_q_ff <= tx_master_clock_i;
      rxclk_q_ff <= rx_master_clock_i;
      txsync_q_ff <= tx_frame_sync_n_i;
      rxsync_q_ff <= rx_frame_sync_n_i;
    end
  end

  logic tx_clk_fall, tx_clk_rise, rx_clk_fall, tx_sync_fall, rx_sync_fall;
  assign tx_clk_fall = fell(txclk_q_ff, tx_master_clock_i);
  assign tx_clk_rise = rose(txclk_q_ff, tx_master_clock_i);
  assign rx_clk_fall = fell(rxclk_q_ff, rx_master_clock_i);
  assign tx_sync_fall = fell(txsync_q_ff, tx_frame_sync_n_i);
  assign rx_sync_fall = fell(rxsync_q_ff, rx_frame_sync_n_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and bus
  logic [2:0] ctrl_ff, nxt_ctrl;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic gain_ff, nxt_gain;
  logic req, take, wr_tx, rx_pop;
  logic [7:0] st_clr;
  logic tx_dis, rx_dis;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [SAMPLE_W-1:0] fifo_data;
  logic [LEVEL_W-1:0] fifo_level;
  logic [31:0] status_word;
  logic [SAMPLE_W-1:0] rx_data_ff, nxt_rx_data;
  logic rx_valid_ff, nxt_rx_valid, rx_over_ff, nxt_rx_over, tx_under_ff, nxt_tx_under;
  logic [1:0] ferr_ff, ferr_set;
  lpc_state_t tx_state_ff, nxt_tx_state, rx_state_ff, nxt_rx_state;

  assign tx_dis = tx_disable_i | ctrl_ff[CTRL_TX_DIS];
  assign rx_dis = rx_disable_i | ctrl_ff[CTRL_RX_DIS];

  always_comb begin
    status_word = '0;
    status_word[ST_TX_BUSY] = (tx_state_ff != ST_IDLE);
    status_word[ST_RX_BUSY] = (rx_state_ff != ST_IDLE);
    status_word[ST_RX_VALID] = rx_valid_ff;
    status_word[ST_TX_UNDER] = tx_under_ff;
    status_word[ST_RX_OVER] = rx_over_ff;
    status_word[ST_TX_FERR] = ferr_ff[0];
    status_word[ST_RX_FERR] = ferr_ff[1];
    status_word[ST_LEVEL_LSB +: LEVEL_W] = fifo_level;
  end

  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wr_tx = req & wb_we_i & (wb_adr_i == ADR_TXDATA);
    // Full FIFO stalls the bus cycle
    take = req & (~wr_tx | fifo_in_ready);
    nxt_ack = take;
    nxt_ctrl = ctrl_ff;
    nxt_dat = dat_ff;
    st_clr = '0;
    rx_pop = 1'b0;
    if (take && wb_we_i) begin
      if (wb_adr_i == ADR_CTRL) begin
        if (wb_sel_i[0]) begin
          nxt_ctrl = wb_dat_i[2:0];
        end
      end else if (wb_adr_i == ADR_STATUS) begin
        if (wb_sel_i[0]) begin
          st_clr = wb_dat_i[7:0];
        end
      end
    end else if (take) begin
      if (wb_adr_i == ADR_CTRL) begin
        nxt_dat = {29'h0, ctrl_ff};
      end else if (wb_adr_i == ADR_STATUS) begin
        nxt_dat = status_word;
      end else if (wb_adr_i == ADR_RXDATA) begin
        nxt_dat = {16'h0, rx_data_ff};
        rx_pop = 1'b1;
      end else begin
        nxt_dat = '0;
      end
    end
    nxt_gain = rx_gain_select_i | ctrl_ff[CTRL_RX_GAIN];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RESET;
      ack_ff <= 1'b0;
      dat_ff <= '0;
      gain_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      gain_ff <= nxt_gain;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign rx_gain_o = gain_ff;

  lpc_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH),
    .LVL_W(LEVEL_W)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(wr_tx),
    .in_ready_o(fifo_in_ready),
    .in_data_i(wb_dat_i[SAMPLE_W-1:0]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data),
    .level_o(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit engine
  logic [SAMPLE_W-1:0] tx_sh_ff, nxt_tx_sh;
  logic [4:0] tx_cnt_ff, nxt_tx_cnt;
  logic tx_do_ff, nxt_tx_do, tx_oe_n_ff, nxt_tx_oe_n, tx_under_set;

  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_do = tx_do_ff;
    nxt_tx_oe_n = tx_oe_n_ff;
    fifo_pop = 1'b0;
    tx_under_set = 1'b0;
    if (tx_dis) begin
      nxt_tx_state = ST_IDLE;
      nxt_tx_oe_n = 1'b1;
    end else begin
      case (tx_state_ff)
        ST_IDLE: begin
          if (tx_sync_fall) begin
            nxt_tx_state = ST_ARM;
          end
        end
        ST_ARM: begin
          if (tx_clk_fall) begin
            nxt_tx_state = ST_SHIFT;
            nxt_tx_cnt = '0;
            fifo_pop = fifo_out_valid;
            nxt_tx_sh = fifo_out_valid ? fifo_data : '0;
            tx_under_set = ~fifo_out_valid;
          end
        end
        ST_SHIFT: begin
          if (tx_clk_rise) begin
            if (tx_cnt_ff == SAMPLE_BITS) begin
              nxt_tx_oe_n = 1'b1;
              nxt_tx_state = ST_IDLE;
            end else begin
              nxt_tx_do = tx_sh_ff[0];
              nxt_tx_oe_n = 1'b0;
              nxt_tx_sh = tx_sh_ff >> 1;
              nxt_tx_cnt = tx_cnt_ff + 5'h01;
            end
          end
        end
        default: begin
          nxt_tx_state = ST_IDLE;
          nxt_tx_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_ff <= ST_IDLE;
      tx_sh_ff <= '0;
      tx_cnt_ff <= '0;
      tx_do_ff <= 1'b0;
      tx_oe_n_ff <= 1'b1;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_sh_ff <= nxt_tx_sh;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_do_ff <= nxt_tx_do;
      tx_oe_n_ff <= nxt_tx_oe_n;
    end
  end

  assign tx_serial_data_o = tx_do_ff;
  assign tx_serial_data_oe_n_o = tx_oe_n_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive engine
  logic [SAMPLE_W-1:0] rx_sh_ff, nxt_rx_sh;
  logic [4:0] rx_cnt_ff, nxt_rx_cnt;
  logic rx_done;

  always_comb begin
    nxt_rx_state = rx_state_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    rx_done = 1'b0;
    if (rx_dis) begin
      nxt_rx_state = ST_IDLE;
    end else begin
      case (rx_state_ff)
        ST_IDLE: begin
          if (rx_sync_fall) begin
            nxt_rx_state = ST_ARM;
          end
        end
        ST_ARM: begin
          if (rx_clk_fall) begin
            nxt_rx_state = ST_SHIFT;
            nxt_rx_cnt = '0;
          end
        end
        ST_SHIFT: begin
          if (rx_clk_fall) begin
            nxt_rx_sh = {rx_serial_data_i, rx_sh_ff[SAMPLE_W-1:1]};
            nxt_rx_cnt = rx_cnt_ff + 5'h01;
            if (rx_cnt_ff == SAMPLE_BITS - 5'h01) begin
              rx_done = 1'b1;
              nxt_rx_state = ST_IDLE;
            end
          end
        end
        default: begin
          nxt_rx_state = ST_IDLE;
        end
      endcase
    end
    nxt_rx_data = rx_done ? nxt_rx_sh : rx_data_ff;
    // Hardware set wins over software clear
    nxt_rx_valid = (rx_valid_ff & ~rx_pop) | rx_done;
    nxt_rx_over = (rx_over_ff & ~st_clr[ST_RX_OVER]) | (rx_done & rx_valid_ff & ~rx_pop);
    nxt_tx_under = (tx_under_ff & ~st_clr[ST_TX_UNDER]) | tx_under_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_ff <= ST_IDLE;
      rx_sh_ff <= '0;
      rx_cnt_ff <= '0;
      rx_data_ff <= '0;
      rx_valid_ff <= 1'b0;
      rx_over_ff <= 1'b0;
      tx_under_ff <= 1'b0;
    end else begin
      rx_state_ff <= nxt_rx_state;
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_data_ff <= nxt_rx_data;
      rx_valid_ff <= nxt_rx_valid;
      rx_over_ff <= nxt_rx_over;
      tx_under_ff <= nxt_tx_under;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame period monitors, index 0 transmit, 1 receive
  logic [1:0] mon_clk_fall, mon_sync_fall;
  assign mon_clk_fall = {rx_clk_fall, tx_clk_fall};
  assign mon_sync_fall = {rx_sync_fall, tx_sync_fall};

  for (genvar i = 0; i < 2; i++) begin : g_mon
    logic [8:0] per_ff, nxt_per;
    logic seen_ff, nxt_seen, nxt_ferr;
    always_comb begin
      nxt_per = per_ff;
      nxt_seen = seen_ff;
      ferr_set[i] = 1'b0;
      // Sync period must be 256 clocks
      if (mon_sync_fall[i]) begin
        ferr_set[i] = seen_ff & (per_ff != FRAME_CLKS);
        nxt_per = '0;
        nxt_seen = 1'b1;
      end else if (mon_clk_fall[i] && per_ff != PER_MAX) begin
        nxt_per = per_ff + 9'h001;
      end
      nxt_ferr = (ferr_ff[i] & ~st_clr[ST_TX_FERR + i]) | ferr_set[i];
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        per_ff <= '0;
        seen_ff <= 1'b0;
        ferr_ff[i] <= 1'b0;
      end else begin
        per_ff <= nxt_per;
        seen_ff <= nxt_seen;
        ferr_ff[i] <= nxt_ferr;
      end
    end
  end
endmodule : lpc_serial_port

// ---- design/lpc_pkg.sv ----
// Constants and types of the linear codec serial port
package lpc_pkg;
  // Sample and frame geometry
  localparam int SAMPLE_W = 16;
  localparam logic [4:0] SAMPLE_BITS = 5'h10;
  localparam logic [8:0] FRAME_CLKS = 9'h100;
  localparam logic [8:0] PER_MAX = 9'h1ff;
  localparam int FIFO_DEPTH = 32;
  localparam int LEVEL_W = 6;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_TXDATA = 8'h08;
  localparam logic [7:0] ADR_RXDATA = 8'h0c;
  // Control fields
  localparam int CTRL_TX_DIS = 0;
  localparam int CTRL_RX_DIS = 1;
  localparam int CTRL_RX_GAIN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Status fields
  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_BUSY = 1;
  localparam int ST_RX_VALID = 2;
  localparam int ST_TX_UNDER = 3;
  localparam int ST_RX_OVER = 4;
  localparam int ST_TX_FERR = 5;
  localparam int ST_RX_FERR = 6;
  localparam int ST_LEVEL_LSB = 8;
  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM = 3'b010,
    ST_SHIFT = 3'b100
  } lpc_state_t;
endpackage : lpc_pkg

// ---- sim/lpc_serial_port_asserts.sv ----
// Checker for the codec serial port pins and bus
`timescale 1ns/1ps
module lpc_serial_port_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Pins
  input wire logic tx_master_clock_i,
  input wire logic tx_frame_sync_n_i,
  input wire logic tx_disable_i,
  input wire logic tx_serial_data_o,
  input wire logic tx_serial_data_oe_n_o,
  input wire logic rx_gain_select_i,
  input wire logic rx_gain_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic mclk_ff;
  logic [4:0] rises_ff;
  logic [4:0] nxt_rises;
  ////////////////////////////////////////////////////////////////////////////
  // Master clock rises while driving
  always_comb begin
    nxt_rises = rises_ff;
    if (tx_serial_data_oe_n_o) begin
      nxt_rises = 5'h00;
    end else if (tx_master_clock_i && !mclk_ff) begin
      nxt_rises = rises_ff + 5'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    mclk_ff <= rst_i ? 1'b0 : tx_master_clock_i;
    rises_ff <= rst_i ? 5'h00 : nxt_rises;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_gain_follows;
    rx_gain_select_i |=> rx_gain_o;
  endproperty
  a_gain_follows: assert property (p_gain_follows)
    else $error("gain select not applied");
  property p_tx_dis;
    tx_disable_i |=> tx_serial_data_oe_n_o;
  endproperty
  a_tx_dis: assert property (p_tx_dis)
    else $error("transmit drives while disabled");
  property p_oe_after_rst;
    $fell(rst_i) |-> tx_serial_data_oe_n_o;
  endproperty
  a_oe_after_rst: assert property (p_oe_after_rst)
    else $error("data pin driven after reset");
  property p_drive_on_rise;
    $fell(tx_serial_data_oe_n_o) |-> $past(tx_master_clock_i);
  endproperty
  a_drive_on_rise: assert property (p_drive_on_rise)
    else $error("first bit not after clock rise");
  property p_bit_on_rise;
    !tx_serial_data_oe_n_o && $past(!tx_serial_data_oe_n_o) && $changed(tx_serial_data_o)
      |-> $past(tx_master_clock_i);
  endproperty
  a_bit_on_rise: assert property (p_bit_on_rise)
    else $error("bit changed outside clock high");
  property p_sixteen_bits;
    $rose(tx_serial_data_oe_n_o) && !$past(tx_disable_i) |-> rises_ff == 5'h10;
  endproperty
  a_sixteen_bits: assert property (p_sixteen_bits)
    else $error("sample length not 16 bits");
  property p_sync_at_start;
    $fell(tx_serial_data_oe_n_o) |-> !tx_frame_sync_n_i;
  endproperty
  a_sync_at_start: assert property (p_sync_at_start)
    else $error("shift started without sync");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_req;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack without request");
endmodule : lpc_serial_port_asserts

bind lpc_serial_port lpc_serial_port_asserts u_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .tx_master_clock_i(tx_master_clock_i),
  .tx_frame_sync_n_i(tx_frame_sync_n_i), .tx_disable_i(tx_disable_i),
  .tx_serial_data_o(tx_serial_data_o), .tx_serial_data_oe_n_o(tx_serial_data_oe_n_o),
  .rx_gain_select_i(rx_gain_select_i), .rx_gain_o(rx_gain_o)
);

// ---- sim/lpc_far_end_model.sv ----
// Frame timing source and serial sink facing the codec port
`timescale 1ns/1ps
module lpc_far_end_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] rx_word_i,
  input wire logic tx_data_i,
  input wire logic tx_oe_n_i,
  output logic mclk_o,
  output logic sync_n_o,
  output logic rx_data_o,
  output logic [15:0] tx_word_o,
  output logic [7:0] tx_cnt_o,
  output logic [7:0] fr_o
);
  logic [1:0] div;
  logic [7:0] per;
  logic [3:0] nbits;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= 2'h0;
      mclk_o <= 1'b0;
      per <= 8'hf0;
      sync_n_o <= 1'b1;
      rx_data_o <= 1'b0;
      nbits <= 4'h0;
      tx_word_o <= 16'h0000;
      tx_cnt_o <= 8'h00;
      fr_o <= 8'h00;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        mclk_o <= ~mclk_o;
        if (!mclk_o) begin
          per <= per + 8'h01;
          sync_n_o <= !(per == 8'hff || per == 8'h00);
          rx_data_o <= (per < 8'h10) ? rx_word_i[per[3:0]] : ~rx_data_o;
          if (per == 8'h13) begin
            fr_o <= fr_o + 8'h01;
          end
        end else if (!tx_oe_n_i) begin
          tx_word_o <= {tx_data_i, tx_word_o[15:1]};
          nbits <= nbits + 4'h1;
          if (nbits == 4'hf) begin
            tx_cnt_o <= tx_cnt_o + 8'h01;
          end
        end
      end
    end
  end
endmodule : lpc_far_end_model

// ---- sim/lpc_serial_port_tb.sv ----
// Testbench for the codec serial port
`timescale 1ns/1ps
module lpc_serial_port_tb
  import lpc_pkg::*;
();
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic tx_disable_i, rx_disable_i, rx_gain_select_i, rx_gain_o;
  logic mclk, sync_n, rx_bit, tx_bit, tx_oe_n;
  logic [15:0] rx_word, tx_word;
  logic [7:0] tx_cnt, fr_cnt;
  int fails, checks_done, wt;
  ////////////////////////////////////////////////////////////////////////////
  // receive gain pin driven by the bench
  // one clock and one sync both ways
  lpc_serial_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_master_clock_i(mclk), .tx_frame_sync_n_i(sync_n), .tx_disable_i(tx_disable_i),
    .tx_serial_data_o(tx_bit), .tx_serial_data_oe_n_o(tx_oe_n), .rx_master_clock_i(mclk),
    .rx_frame_sync_n_i(sync_n), .rx_serial_data_i(rx_bit), .rx_disable_i(rx_disable_i),
    .rx_gain_select_i(rx_gain_select_i), .rx_gain_o(rx_gain_o));
  lpc_far_end_model u_far (.clk_i(clk_i), .rst_i(rst_i), .rx_word_i(rx_word),
    .tx_data_i(tx_bit), .tx_oe_n_i(tx_oe_n), .mclk_o(mclk), .sync_n_o(sync_n),
    .rx_data_o(rx_bit), .tx_word_o(tx_word), .tx_cnt_o(tx_cnt), .fr_o(fr_cnt));
  always #25 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wt = 0;
    do begin
      @(posedge clk_i);
      wt++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wait_frame();
    logic [7:0] f0;
    f0 = fr_cnt;
    while (fr_cnt === f0) begin
      @(posedge clk_i);
    end
  endtask : wait_frame
  function automatic logic [15:0] val(input int i);
    return 16'h8001 ^ (16'(i) * 16'h0111);
  endfunction : val
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {tx_disable_i, rx_disable_i, rx_gain_select_i} = 3'h0;
    rst_i = 1'b1;
    rx_word = 16'h8c35;
    fails = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    wb(1'b1, 8'h10, 32'hffffffff);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    rx_gain_select_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("gain pin", rx_gain_o, 32'h1);
    rx_gain_select_i <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("gain reg", rx_gain_o, 32'h1);
    wb(1'b1, ADR_CTRL, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("gain off", rx_gain_o, 32'h0);
    // Empty queue frame
    wait_frame();
    chk("tx underrun", tx_word, 32'h0);
    chk("tx count", tx_cnt, 32'h1);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("status", rd & 32'h3f7c, 32'hc);
    wb(1'b0, ADR_RXDATA, 32'h0);
    chk("rx word", rd, 32'h8c35);
    wb(1'b1, ADR_STATUS, 32'h78);
    // Fill until refused
    for (int i = 0; i < 32; i++) begin
      wb(1'b1, ADR_TXDATA, {16'hdead, val(i)});
    end
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("level", rd[13:8], 32'h20);
    wb(1'b1, ADR_TXDATA, {16'h0, val(32)});
    chk("full stall", wt > 20, 32'h1);
    for (int k = 0; k < 33; k++) begin
      wait_frame();
      chk("tx word", tx_word, val(k));
      chk("released", tx_oe_n, 32'h1);
      rx_word <= ~val(k);
    end
    chk("frames", tx_cnt, 32'h22);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("overrun", rd & 32'h3f70, 32'h10);
    wb(1'b0, ADR_RXDATA, 32'h0);
    chk("rx last", rd, {16'h0, ~val(31)});
    // Both sides disabled for one frame
    wb(1'b1, ADR_TXDATA, 32'h1234);
    tx_disable_i <= 1'b1;
    rx_disable_i <= 1'b1;
    rx_word <= 16'h4321;
    wait_frame();
    chk("tx held", tx_cnt, 32'h22);
    wb(1'b0, ADR_RXDATA, 32'h0);
    chk("rx held", rd, {16'h0, ~val(31)});
    tx_disable_i <= 1'b0;
    rx_disable_i <= 1'b0;
    // Both sides disabled by control bits for one frame
    wb(1'b1, ADR_CTRL, 32'h3);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl rw", rd, 32'h3);
    wait_frame();
    chk("tx reg held", tx_cnt, 32'h22);
    wb(1'b0, ADR_RXDATA, 32'h0);
    chk("rx reg held", rd, {16'h0, ~val(31)});
    wb(1'b1, ADR_CTRL, 32'h0);
    wait_frame();
    chk("tx resumed", tx_word, 32'h1234);
    chk("tx count", tx_cnt, 32'h23);
    wb(1'b0, ADR_RXDATA, 32'h0);
    chk("rx resumed", rd, 32'h4321);
    give_verdict();
  end
endmodule : lpc_serial_port_tb
